/* File: bench/sir_optics_model.sv */
// Optical transceiver model: light pulses on command, emitter flashes counted.
`timescale 1ns/1ps
`default_nettype none
module sir_optics_model (
   input wire logic mclk,
   input wire logic ir_pulse_out,
   output logic ir_pulse_in,
   output int lit_count
);
   // The receiver output idles high between pulses, so a released line reads as no light.
   initial begin
      ir_pulse_in = 1'b1;
   end
   always @(posedge ir_pulse_out) lit_count++;
   task automatic flash(input int low_cycles, input int gap);
      @(posedge mclk);
      #1 ir_pulse_in = 1'b0;
      repeat (low_cycles) @(posedge mclk);
      #1 ir_pulse_in = 1'b1;
      repeat (gap) @(posedge mclk);
      // Return off the edge so the caller never samples or drives in the edge's time step.
      #1;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb_infrared_sir_pulse_endec.sv */
// Self-checking bench for the serial infrared pulse encoder and decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_infrared_sir_pulse_endec;
   import sir_endec_pkg::*;
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic state_reset_n = 1'b1;
   logic uart_serial_out = 1'b1;
   logic uart_serial_in;
   logic ir_pulse_in;
   logic ir_pulse_out;
   logic baud16_clock = 1'b0;
   logic crystal_in = 1'b0;
   logic crystal_out;
   logic ext_clock_select = 1'b1;
   logic fixed_pulse_enable = 1'b0;
   logic osc_sleep = 1'b0;
   logic [2:0] rate = 3'h0;
   logic osc_power_on;
   endec_status_t status;
   int failures = 0;
   int n_checks = 0;
   int dly;
   int wid;
   int lit_count;
   // Code seven has no assigned rate, so the block divides by two as for code zero.
   int div_tab[8] = '{2, 4, 12, 24, 6, 48, 96, 2};
   infrared_sir_pulse_endec u_dut (.mclk(mclk), .reset_n(reset_n),
      .state_reset_n(state_reset_n), .uart_serial_out(uart_serial_out),
      .uart_serial_in(uart_serial_in), .ir_pulse_in(ir_pulse_in), .ir_pulse_out(ir_pulse_out),
      .baud16_clock(baud16_clock), .crystal_in(crystal_in), .crystal_out(crystal_out),
      .ext_clock_select(ext_clock_select), .fixed_pulse_enable(fixed_pulse_enable),
      .osc_sleep(osc_sleep), .rate_sel_bit0(rate[0]), .rate_sel_bit1(rate[1]),
      .rate_sel_bit2(rate[2]), .osc_power_on(osc_power_on), .status(status));
   sir_optics_model u_optics (.mclk(mclk), .ir_pulse_out(ir_pulse_out),
      .ir_pulse_in(ir_pulse_in), .lit_count(lit_count));
   ////////////////////////////////////////////////////////////////////////////////
   always #2.5 mclk = ~mclk;
   // Both outside clocks start off the system clock's phase so no edge ever coincides with a rising system clock edge.
   initial begin
      #7;
      forever #24 baud16_clock = ~baud16_clock;
   end
   initial begin
      #3;
      forever #20 crystal_in = ~crystal_in;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic inr(input int v, input int lo, input int hi);
      return v >= lo && v <= hi;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Which set watches the receive line for a low, clear the emitter for a high.
   task automatic measure(input bit which, input int limit);
      dly = 0;
      wid = 0;
      while ((which ? ~uart_serial_in : ir_pulse_out) !== 1'b1 && dly < limit) begin
         cyc(1);
         dly++;
      end
      while ((which ? ~uart_serial_in : ir_pulse_out) === 1'b1 && wid < 20000) begin
         cyc(1);
         wid++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_ext_encode();
      int base;
      osc_sleep = 1'b1;
      cyc(6);
      base = lit_count;
      check("osc off", osc_power_on, 1'b0);
      check("xtal out off", crystal_out, 1'b0);
      uart_serial_out = 1'b0;
      measure(0, 200);
      check("lead", inr(dly, 58, 78), 1'b1);
      check("mark", inr(wid, 27, 31), 1'b1);
      check("tx busy", status.tx_busy, 1'b1);
      measure(0, 200);
      check("next zero", inr(dly, 120, 130), 1'b1);
      uart_serial_out = 1'b1;
      measure(0, 200);
      check("one bit", dly, 200);
      check("tx idle", status.tx_busy, 1'b0);
      check("flashes", lit_count - base, 2);
   endtask
   task automatic t_rate_codes();
      ext_clock_select = 1'b0;
      osc_sleep = 1'b0;
      for (int c = 0; c < 8; c++) begin
         rate = c[2:0];
         cyc(6);
         check("osc on", osc_power_on, 1'b1);
         uart_serial_out = 1'b0;
         measure(0, 70 * div_tab[c] + 20);
         check("xtal mark", inr(wid, 24 * div_tab[c] - 2, 24 * div_tab[c] + 2), 1'b1);
         uart_serial_out = 1'b1;
         cyc(64 * div_tab[c]);
      end
   endtask
   task automatic t_monoshot();
      fixed_pulse_enable = 1'b1;
      for (int c = 0; c < 6; c += 5) begin
         rate = c[2:0];
         cyc(6);
         uart_serial_out = 1'b0;
         measure(0, 70 * div_tab[c] + 20);
         check("mono width", inr(wid, 46, 50), 1'b1);
         uart_serial_out = 1'b1;
         cyc(128 * div_tab[c]);
      end
      fixed_pulse_enable = 1'b0;
   endtask
   task automatic t_decode();
      ext_clock_select = 1'b1;
      cyc(6);
      fork
         u_optics.flash(200, 10);
         measure(1, 400);
      join
      check("short drop", dly, 400);
      fork
         u_optics.flash(326, 10);
         measure(1, 400);
      join
      check("accept", inr(dly, 326, 338), 1'b1);
      check("stretch", inr(wid, 143, 162), 1'b1);
      check("long kind", status.rx_short_pulse, 1'b0);
   endtask
   task automatic t_fifo_fill();
      ext_clock_select = 1'b0;
      osc_sleep = 1'b1;
      rate = 3'h0;
      cyc(6);
      repeat (11) u_optics.flash(330, 12);
      check("full", status.rx_fifo_full, 1'b1);
      check("overrun", status.rx_overrun, 1'b1);
      check("rx held", uart_serial_in, 1'b0);
      check("short kind", status.rx_short_pulse, 1'b1);
      osc_sleep = 1'b0;
      dly = 0;
      while (status.rx_busy !== 1'b0 && dly < 5000) begin
         cyc(1);
         dly++;
      end
      check("drain", inr(dly, 2450, 2700), 1'b1);
      check("emptied", status.rx_fifo_full, 1'b0);
      check("sticky", status.rx_overrun, 1'b1);
      state_reset_n = 1'b0;
      cyc(6);
      check("ovr clear", status.rx_overrun, 1'b0);
      state_reset_n = 1'b1;
      cyc(6);
   endtask
   task automatic t_state_reset();
      ext_clock_select = 1'b1;
      cyc(6);
      u_optics.flash(330, 20);
      uart_serial_out = 1'b0;
      cyc(20);
      state_reset_n = 1'b0;
      cyc(6);
      check("rx cut", uart_serial_in, 1'b1);
      state_reset_n = 1'b1;
      measure(0, 200);
      check("enc cut", dly, 200);
      uart_serial_out = 1'b1;
      cyc(10);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge mclk);
      #1;
      check("ir in reset", ir_pulse_out, 1'b0);
      check("rx in reset", uart_serial_in, 1'b1);
      reset_n = 1'b1;
      cyc(8);
      t_ext_encode();
      t_rate_codes();
      t_monoshot();
      t_decode();
      t_fifo_fill();
      t_state_reset();
      close_out();
   end
   // The full run needs a little over half of this span.
   initial begin
      #450000;
      failures++;
      close_out();
   end
endmodule
`default_nettype wire

/* File: rtl/infrared_sir_pulse_endec.sv */
// Serial infrared pulse encoder and decoder between a UART and an optical transceiver.
`timescale 1ns/1ps
`default_nettype none
`include "sir_endec_defs.svh"
module infrared_sir_pulse_endec #(
   parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic state_reset_n,
   input wire logic uart_serial_out,
   output logic uart_serial_in,
   input wire logic ir_pulse_in,
   output logic ir_pulse_out,
   input wire logic baud16_clock,
   input wire logic crystal_in,
   output logic crystal_out,
   input wire logic ext_clock_select,
   input wire logic fixed_pulse_enable,
   input wire logic osc_sleep,
   input wire logic rate_sel_bit0,
   input wire logic rate_sel_bit1,
   input wire logic rate_sel_bit2,
   output logic osc_power_on,
   output sir_endec_pkg::endec_status_t status
);
   import sir_endec_pkg::*;

   localparam logic [8:0] MIN_CNT = 9'(`MIN_PULSE_CYCLES - 1);

   pin_bundle_t pin_raw;
   pin_bundle_t pin_meta;
   pin_bundle_t pin_q;
   pin_bundle_t pin_prev;
   logic srst;
   logic baud_rise;
   logic xtal_rise;
   logic xtal_tick;
   logic tick;
   logic [6:0] div_cnt;
   logic [6:0] divisor;
   enc_state_t enc_state;
   logic [3:0] enc_phase;
   logic enc_mark;
   logic enc_mark_q;
   logic enc_rise;
   logic txd_fell;
   logic [2:0] mono_cnt;
   logic ir_fell;
   logic ir_rose;
   logic measuring;
   logic [8:0] meas_cnt;
   logic [1:0] meas_ticks;
   logic pend_valid;
   rx_event_t pend_event;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   rx_event_t fifo_out_event;
   dec_state_t dec_state;
   logic [3:0] dec_cnt;
   logic last_short;
   logic overrun;
   logic pulse_done;
   logic pulse_ok;

   function automatic logic [6:0] div_for(input logic [2:0] code);
      logic [6:0] d;
      d = `DIV_UNUSED;
      unique case (code)
         3'h0: d = `DIV_CODE0;
         3'h1: d = `DIV_CODE1;
         3'h2: d = `DIV_CODE2;
         3'h3: d = `DIV_CODE3;
         3'h4: d = `DIV_CODE4;
         3'h5: d = `DIV_CODE5;
         3'h6: d = `DIV_CODE6;
         3'h7: d = `DIV_UNUSED;
      endcase
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Every pin is asynchronous to mclk, so each bit passes two flip-flops.

   assign pin_raw.srst_n = state_reset_n;
   assign pin_raw.ext_sel = ext_clock_select;
   assign pin_raw.fixed = fixed_pulse_enable;
   assign pin_raw.sleep = osc_sleep;
   assign pin_raw.rate = {rate_sel_bit2, rate_sel_bit1, rate_sel_bit0};
   assign pin_raw.baud16 = baud16_clock;
   assign pin_raw.xtal = crystal_in;
   assign pin_raw.txd = uart_serial_out;
   assign pin_raw.ir_rx = ir_pulse_in;

   localparam logic [10:0] PIN_RST = `PIN_RESET;

   genvar gi;
   generate
      for (gi = 0; gi < $bits(pin_bundle_t); gi++) begin : g_sync
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               pin_meta[gi] <= PIN_RST[gi];
               pin_q[gi] <= PIN_RST[gi];
               pin_prev[gi] <= PIN_RST[gi];
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_q[gi] <= pin_meta[gi];
               pin_prev[gi] <= pin_q[gi];
            end
         end
      end
   endgenerate

   assign srst = !pin_q.srst_n;
   assign txd_fell = pin_prev.txd && !pin_q.txd;
   assign ir_fell = pin_prev.ir_rx && !pin_q.ir_rx;
   assign ir_rose = !pin_prev.ir_rx && pin_q.ir_rx;

   ////////////////////////////////////////////////////////////////////////////
   // Clock source: external 16x clock or divided crystal.

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         osc_power_on <= 1'b0;
         crystal_out <= 1'b0;
      end else begin
         osc_power_on <= !(pin_q.ext_sel || pin_q.sleep);
         crystal_out <= osc_power_on && !pin_q.xtal;
      end
   end

   // The sleep input only gates the crystal path; on that path the state machines keep their state but get no ticks.
   assign xtal_rise = osc_power_on && pin_q.xtal && !pin_prev.xtal;
   assign baud_rise = pin_q.baud16 && !pin_prev.baud16;
   assign divisor = div_for(pin_q.rate);
   assign xtal_tick = xtal_rise && (div_cnt >= divisor - 7'h01);
   assign tick = pin_q.ext_sel ? baud_rise : xtal_tick;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt <= 7'h00;
      end else if (!osc_power_on) begin
         div_cnt <= 7'h00;
      end else if (xtal_rise) begin
         div_cnt <= xtal_tick ? 7'h00 : div_cnt + 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Encoder: one pulse per zero bit, placed in the middle of the bit.

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         enc_state <= ENC_IDLE;
         enc_phase <= 4'h0;
      end else if (srst) begin
         enc_state <= ENC_IDLE;
         enc_phase <= 4'h0;
      end else begin
         unique case (enc_state)
            ENC_IDLE: begin
               if (txd_fell) begin
                  enc_state <= ENC_LEAD;
                  enc_phase <= 4'h0;
               end
            end
            ENC_LEAD: begin
               if (tick) begin
                  enc_phase <= enc_phase + 4'h1;
                  if (enc_phase == 4'(`LEAD_TICKS - 1)) begin
                     enc_state <= ENC_MARK;
                  end
               end
            end
            ENC_MARK: begin
               if (tick) begin
                  enc_phase <= enc_phase + 4'h1;
                  if (enc_phase == 4'(`LEAD_TICKS + `MARK_TICKS - 1)) begin
                     enc_state <= ENC_TAIL;
                  end
               end
            end
            ENC_TAIL: begin
               if (tick) begin
                  if (enc_phase == 4'(`TICKS_PER_BIT - 1)) begin
                     enc_phase <= 4'h0;
                     enc_state <= pin_q.txd ? ENC_IDLE : ENC_LEAD;
                  end else begin
                     enc_phase <= enc_phase + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   assign enc_mark = (enc_state == ENC_MARK);
   assign enc_rise = enc_mark && !enc_mark_q;

   // The monoshot counts crystal edges, so its width ignores the rate code.
   // It is only meaningful with the crystal path; on the 16x clock it may stall.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         enc_mark_q <= 1'b0;
         mono_cnt <= 3'h0;
      end else if (srst) begin
         enc_mark_q <= 1'b0;
         mono_cnt <= 3'h0;
      end else begin
         enc_mark_q <= enc_mark;
         if (pin_q.fixed && enc_rise) begin
            mono_cnt <= 3'(`MONO_XTAL_CYCLES);
         end else if (xtal_rise && mono_cnt != 3'h0) begin
            mono_cnt <= mono_cnt - 3'h1;
         end
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ir_pulse_out <= 1'b0;
      end else if (srst) begin
         ir_pulse_out <= 1'b0;
      end else begin
         ir_pulse_out <= pin_q.fixed ? (mono_cnt != 3'h0) : enc_mark;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoder front end: measure each low pulse on the infrared input.

   assign pulse_done = measuring && ir_rose;
   assign pulse_ok = pulse_done && (meas_cnt >= MIN_CNT);

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         measuring <= 1'b0;
         meas_cnt <= 9'h000;
         meas_ticks <= 2'h0;
      end else if (srst || ir_fell) begin
         measuring <= !srst;
         meas_cnt <= 9'h000;
         meas_ticks <= 2'h0;
      end else if (pulse_done) begin
         measuring <= 1'b0;
      end else if (measuring) begin
         if (meas_cnt != 9'h1FF) begin
            meas_cnt <= meas_cnt + 9'h001;
         end
         if (tick && meas_ticks != 2'h3) begin
            meas_ticks <= meas_ticks + 2'h1;
         end
      end
   end

   // A pending event waits for FIFO space; a second pulse meanwhile is lost.
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pend_valid <= 1'b0;
         pend_event <= '0;
         overrun <= 1'b0;
      end else if (srst) begin
         pend_valid <= 1'b0;
         pend_event <= '0;
         overrun <= 1'b0;
      end else begin
         if (pulse_ok && pend_valid && !fifo_in_ready) begin
            overrun <= 1'b1;
         end else if (pulse_ok) begin
            pend_valid <= 1'b1;
            pend_event.short_pulse <= (meas_ticks < 2'(`SHORT_TICKS));
         end else if (fifo_in_ready) begin
            pend_valid <= 1'b0;
         end
      end
   end

   sir_event_fifo #(
      .WIDTH($bits(rx_event_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .mclk(mclk),
      .reset_n(reset_n),
      .clear(srst),
      .in_valid(pend_valid),
      .in_ready(fifo_in_ready),
      .in_data(pend_event),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_event)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decoder back end: stretch every accepted pulse to one bit time.

   assign fifo_out_ready = (dec_state == DEC_IDLE) ||
      (tick && dec_cnt == 4'(`TICKS_PER_BIT - 1));

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         dec_state <= DEC_IDLE;
         dec_cnt <= 4'h0;
         last_short <= 1'b0;
      end else if (srst) begin
         dec_state <= DEC_IDLE;
         dec_cnt <= 4'h0;
         last_short <= 1'b0;
      end else begin
         unique case (dec_state)
            DEC_IDLE: begin
               if (fifo_out_valid) begin
                  dec_state <= DEC_STRETCH;
                  dec_cnt <= 4'h0;
                  last_short <= fifo_out_event.short_pulse;
               end
            end
            DEC_STRETCH: begin
               if (tick) begin
                  dec_cnt <= dec_cnt + 4'h1;
                  if (dec_cnt == 4'(`TICKS_PER_BIT - 1)) begin
                     // Back-to-back zeros chain without a high glitch between them.
                     dec_state <= fifo_out_valid ? DEC_STRETCH : DEC_IDLE;
                     if (fifo_out_valid) begin
                        last_short <= fifo_out_event.short_pulse;
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         uart_serial_in <= 1'b1;
         status <= '0;
      end else if (srst) begin
         uart_serial_in <= 1'b1;
         status <= '0;
      end else begin
         uart_serial_in <= (dec_state != DEC_STRETCH);
         status.tx_busy <= (enc_state != ENC_IDLE);
         status.rx_busy <= (dec_state == DEC_STRETCH);
         status.rx_short_pulse <= last_short;
         status.rx_fifo_full <= !fifo_in_ready;
         status.rx_overrun <= overrun;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   a_reset_outputs: assert property (srst |=> !ir_pulse_out && uart_serial_in)
      else $error("Outputs not idle during state reset.");
   a_reset_machines: assert property (srst |=> enc_state == ENC_IDLE && dec_state == DEC_IDLE)
      else $error("State machines not cleared by state reset.");
   a_lead_start: assert property (enc_state == ENC_IDLE && txd_fell && !srst
      |=> enc_state == ENC_LEAD && enc_phase == 4'h0)
      else $error("Transmit falling edge did not start a zero bit.");
   a_mark_entry: assert property ($rose(enc_mark) |-> enc_phase == 4'h7)
      else $error("Pulse started at the wrong tick.");
   a_mark_exit: assert property ($fell(enc_mark) && !$past(srst) |-> enc_phase == 4'hA)
      else $error("Pulse ended at the wrong tick.");
   a_mono_load: assert property (pin_q.fixed && enc_rise && !srst |=> mono_cnt == 3'h6)
      else $error("Monoshot not loaded with six crystal cycles.");
   a_mono_hold: assert property (mono_cnt != 3'h0 && !xtal_rise && !enc_rise && !srst
      |=> $stable(mono_cnt))
      else $error("Monoshot moved without a crystal edge.");
   a_std_output: assert property (!pin_q.fixed && !srst |=> ir_pulse_out == $past(enc_mark))
      else $error("Standard pulse output does not follow the modulator.");
   a_osc_power: assert property (pin_q.ext_sel || pin_q.sleep |=> !osc_power_on ##1 !xtal_tick)
      else $error("Oscillator path still running while powered down.");
   a_rx_min_width: assert property (pend_valid && !$past(pend_valid) |-> $past(meas_cnt) >= MIN_CNT)
      else $error("Short glitch accepted as an infrared pulse.");
   a_rx_stretch_end: assert property (dec_state == DEC_STRETCH && tick && dec_cnt == 4'hF
      && !fifo_out_valid && !srst |=> dec_state == DEC_IDLE ##1 uart_serial_in)
      else $error("Receive low not ended after one bit time.");
   a_rx_low: assert property (dec_state == DEC_STRETCH && !srst |=> !uart_serial_in)
      else $error("Receive line high during a stretched pulse.");

   c_zero_pulse: cover property ($fell(enc_mark) && !pin_q.fixed);
   c_monoshot: cover property ($fell(mono_cnt != 3'h0));
   c_rx_chain: cover property (dec_state == DEC_STRETCH && fifo_out_ready && fifo_out_valid);
   c_fifo_full: cover property (!fifo_in_ready);

endmodule
`default_nettype wire

/* File: rtl/sir_endec_defs.svh */
// Constants of the serial infrared pulse encoder and decoder.
`ifndef SIR_ENDEC_DEFS_SVH
`define SIR_ENDEC_DEFS_SVH

`define MCLK_PERIOD_PS 5000
`define MIN_PULSE_NS 1628
`define MIN_PULSE_CYCLES ((`MIN_PULSE_NS * 1000 + `MCLK_PERIOD_PS - 1) / `MCLK_PERIOD_PS)
`define TICKS_PER_BIT 16
`define LEAD_TICKS 7
`define MARK_TICKS 3
`define SHORT_TICKS 3
`define MONO_XTAL_CYCLES 6
`define DIV_CODE0 7'h02
`define DIV_CODE1 7'h04
`define DIV_CODE2 7'h0C
`define DIV_CODE3 7'h18
`define DIV_CODE4 7'h06
`define DIV_CODE5 7'h30
`define DIV_CODE6 7'h60
`define DIV_UNUSED 7'h02
`define PIN_RESET 11'h003
`define FIFO_DEPTH_DEF 8

`endif

/* File: rtl/sir_endec_pkg.sv */
// Types shared by the serial infrared pulse encoder and decoder.
package sir_endec_pkg;

   typedef enum logic [1:0] {
      ENC_IDLE = 2'b00,
      ENC_LEAD = 2'b01,
      ENC_MARK = 2'b10,
      ENC_TAIL = 2'b11
   } enc_state_t;

   typedef enum logic {
      DEC_IDLE = 1'b0,
      DEC_STRETCH = 1'b1
   } dec_state_t;

   typedef struct packed {
      logic srst_n;
      logic ext_sel;
      logic fixed;
      logic sleep;
      logic [2:0] rate;
      logic baud16;
      logic xtal;
      logic txd;
      logic ir_rx;
   } pin_bundle_t;

   typedef struct packed {
      logic short_pulse;
   } rx_event_t;

   typedef struct packed {
      logic tx_busy;
      logic rx_busy;
      logic rx_short_pulse;
      logic rx_fifo_full;
      logic rx_overrun;
   } endec_status_t;

endpackage

/* File: rtl/sir_event_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module sir_event_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 8
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clear,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic push;
   logic pop;

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("FIFO depth must be a power of two of at least two.");
      end
   endgenerate

   assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
   assign out_valid = (wr_ptr != rd_ptr);
   assign out_data = store[rd_ptr[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else if (clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         store[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   a_fifo_bounds: assert property (@(posedge mclk) disable iff (!reset_n)
      (wr_ptr - rd_ptr) <= (AW + 1)'(DEPTH))
      else $error("FIFO fill level exceeds its depth.");

endmodule
`default_nettype wire
